//--- pld_cfg.svh
`ifndef PLD_CFG_SVH
`define PLD_CFG_SVH
// Register map (word offsets on the plain register port)
`define PLD_ADDR_CONFIG 4'h0
`define PLD_ADDR_STATUS 4'h1
`define PLD_ADDR_IRQ_STAT 4'h2
`define PLD_ADDR_IRQ_MASK 4'h3
// Configuration field positions
`define PLD_BIT_FINE_EN 7
`define PLD_BIT_INACT 6
`define PLD_BIT_NARROW 5
`define PLD_WIN_HI 2
`define PLD_WIN_LO 0
`define PLD_CONFIG_RST 8'ha2
// Writable bits of the configuration register; bits 4:3 unused
`define PLD_CONFIG_WMASK 8'he7
// Qualification time, in milliseconds, before lock is declared
`define PLD_QUAL_MS 1500
`define PLD_CLK_KHZ 20000
`define PLD_QUAL_CYC (`PLD_QUAL_MS * `PLD_CLK_KHZ)
// Interrupt status and mask bit positions
`define PLD_EV_LOST 0
`define PLD_EV_LOCKED 1
`endif

//--- pld_pkg.sv
package pld_pkg;
   typedef enum logic [1:0] {
      PLD_ACQUIRE = 2'b00,
      PLD_QUALIFY = 2'b01,
      PLD_LOCKED = 2'b10
   } pld_state_e;
   typedef enum logic {
      PLD_RELOCK_EDGE = 1'b0,
      PLD_RELOCK_FULL = 1'b1
   } pld_relock_e;
endpackage : pld_pkg

//--- pld_phase_loss_detector.sv
// How it works
// - Fine window disabled: window ignored entirely
// - Inactivity-unlock set: inactivity raises phase lost
// - Not lost: relock to nearest edge
// - Window field resets to 010
// - Lock declared after in-window qualification time
// - Leaving window gives immediate loss
// - Window width proportional to field value plus one
`timescale 1ns/1ps
`include "pld_cfg.svh"
module pld_phase_loss_detector #(
   parameter int PHASE_W = 16,
   parameter int WIN_UNIT = 1024,
   parameter int QUAL_CYCLES = `PLD_QUAL_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [PHASE_W-1:0] phase_err_mag,
   input wire logic phase_valid,
   input wire logic ref_active,
   input wire logic coarse_loss,
   output logic lock_indication_status,
   output logic phase_lost,
   output pld_pkg::pld_relock_e relock_mode,
   output logic irq
);
   typedef struct packed {
      logic [7:0] config_reg;
      logic [1:0] irq_stat_reg;
      logic [1:0] irq_mask_reg;
      pld_pkg::pld_state_e state_reg;
      logic [31:0] qual_cnt_reg;
      logic lost_reg;
      logic [7:0] rdata_reg;
      logic active_s1_reg;
      logic active_s2_reg;
   } pld_state_s;

   pld_state_s st_reg;
   pld_state_s st_next;

   // Window limit grows linearly with the size field, 000 smallest
   function automatic logic [PHASE_W:0] win_limit(input logic [2:0] sz);
      win_limit = (PHASE_W+1)'((32'(sz) + 32'd1) * 32'(WIN_UNIT));
   endfunction : win_limit

   logic fine_en;
   logic in_window;
   logic fine_loss;
   logic inact_loss;
   logic loss_now;

   // Loss detection terms
   always_comb begin
      fine_en = st_reg.config_reg[`PLD_BIT_FINE_EN];
      in_window = ({1'b0, phase_err_mag} <=
                   win_limit(st_reg.config_reg[`PLD_WIN_HI:`PLD_WIN_LO]));
      fine_loss = fine_en && phase_valid && !in_window;
      inact_loss = st_reg.config_reg[`PLD_BIT_INACT] &&
                   !st_reg.active_s2_reg;
      loss_now = fine_loss || inact_loss || coarse_loss;
   end

   // Next state: registers, lock qualification, events
   always_comb begin
      st_next = st_reg;
      st_next.active_s1_reg = ref_active;
      st_next.active_s2_reg = st_reg.active_s1_reg;
      st_next.rdata_reg = 8'h00;
      // Register writes
      if (reg_wr) begin
         if (reg_addr == `PLD_ADDR_CONFIG) begin
            st_next.config_reg = reg_wdata & `PLD_CONFIG_WMASK;
         end else if (reg_addr == `PLD_ADDR_IRQ_STAT) begin
            st_next.irq_stat_reg = st_reg.irq_stat_reg & ~reg_wdata[1:0];
         end else if (reg_addr == `PLD_ADDR_IRQ_MASK) begin
            st_next.irq_mask_reg = reg_wdata[1:0];
         end
      end
      // Register reads, data in next cycle
      if (reg_rd) begin
         if (reg_addr == `PLD_ADDR_CONFIG) begin
            st_next.rdata_reg = st_reg.config_reg;
         end else if (reg_addr == `PLD_ADDR_STATUS) begin
            st_next.rdata_reg = {5'h00, st_reg.state_reg == pld_pkg::PLD_LOCKED,
                                 st_reg.lost_reg,
                                 st_reg.state_reg == pld_pkg::PLD_LOCKED};
         end else if (reg_addr == `PLD_ADDR_IRQ_STAT) begin
            st_next.rdata_reg = {6'h00, st_reg.irq_stat_reg};
         end else if (reg_addr == `PLD_ADDR_IRQ_MASK) begin
            st_next.rdata_reg = {6'h00, st_reg.irq_mask_reg};
         end
      end
      // Lock state machine
      case (st_reg.state_reg)
         pld_pkg::PLD_ACQUIRE: begin
            st_next.qual_cnt_reg = 32'h0;
            if (!loss_now) begin
               st_next.state_reg = pld_pkg::PLD_QUALIFY;
            end
         end
         pld_pkg::PLD_QUALIFY: begin
            if (loss_now) begin
               st_next.state_reg = pld_pkg::PLD_ACQUIRE;
               st_next.qual_cnt_reg = 32'h0;
            end else if (st_reg.qual_cnt_reg >= 32'(QUAL_CYCLES - 1)) begin
               st_next.state_reg = pld_pkg::PLD_LOCKED;
               st_next.lost_reg = 1'b0;
               st_next.irq_stat_reg[`PLD_EV_LOCKED] = 1'b1;
            end else begin
               st_next.qual_cnt_reg = st_reg.qual_cnt_reg + 32'h1;
            end
         end
         pld_pkg::PLD_LOCKED: begin
            if (loss_now) begin
               st_next.state_reg = pld_pkg::PLD_ACQUIRE;
               st_next.lost_reg = 1'b1;
               st_next.irq_stat_reg[`PLD_EV_LOST] = 1'b1;
            end
         end
         default: begin
            st_next.state_reg = pld_pkg::PLD_ACQUIRE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.config_reg <= `PLD_CONFIG_RST;
         st_reg.irq_mask_reg <= 2'h0;
         st_reg.state_reg <= pld_pkg::PLD_ACQUIRE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign reg_rdata = st_reg.rdata_reg;
   assign lock_indication_status = (st_reg.state_reg == pld_pkg::PLD_LOCKED);
   assign phase_lost = st_reg.lost_reg;
   // Nearest edge until loss, full acquisition until lock is declared again
   assign relock_mode = st_reg.lost_reg ? pld_pkg::PLD_RELOCK_FULL
                                        : pld_pkg::PLD_RELOCK_EDGE;
   assign irq = |(st_reg.irq_stat_reg & st_reg.irq_mask_reg);
endmodule : pld_phase_loss_detector

//--- pld_props.sv
`timescale 1ns/1ps
module pld_props #(
   parameter int QUAL_CYCLES = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic coarse_loss,
   input wire logic lock_indication_status,
   input wire logic phase_lost,
   input wire pld_pkg::pld_relock_e relock_mode
);
   // One clock domain for every check
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_quiet;
      !lock_indication_status [*4];
   endsequence
   property p_relock;
      (relock_mode == pld_pkg::PLD_RELOCK_FULL) == phase_lost;
   endproperty
   a_relock: assert property (p_relock) else $error("bad relock");
   property p_coarse;
      lock_indication_status && coarse_loss |=> phase_lost;
   endproperty
   a_coarse: assert property (p_coarse) else $error("no loss");
   property p_qual;
      coarse_loss |=> s_quiet;
   endproperty
   a_qual: assert property (p_qual) else $error("early lock");
   property p_excl;
      !(lock_indication_status && phase_lost);
   endproperty
   a_excl: assert property (p_excl) else $error("lock and lost");
   property p_rise;
      $rose(phase_lost) |-> $past(lock_indication_status);
   endproperty
   a_rise: assert property (p_rise) else $error("bad loss");
   property p_clr;
      $fell(phase_lost) |-> lock_indication_status;
   endproperty
   a_clr: assert property (p_clr) else $error("bad clear");
   property p_hold;
      phase_lost |=> phase_lost || lock_indication_status;
   endproperty
   a_hold: assert property (p_hold) else $error("lost dropped");
   property p_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("rdata idle");
endmodule : pld_props
bind pld_phase_loss_detector pld_props #(.QUAL_CYCLES(QUAL_CYCLES)) i_p (.*);

//--- phase_loss_detector_test.sv
`timescale 1ns/1ps
module phase_loss_detector_test;
   logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic [15:0] phase_err_mag = 16'h0000;
   logic phase_valid = 0, ref_active = 1, coarse_loss = 0;
   logic lock_indication_status, phase_lost, irq;
   pld_pkg::pld_relock_e relock_mode;
   int errors = 0, checked = 0;
   pld_phase_loss_detector #(.QUAL_CYCLES(4)) i_dut (.*);
   // Clock
   initial forever #25 clk = ~clk;
   task ck(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : ck
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 ck("rdata", e, reg_rdata);
   endtask : rd
   // Wait, then compare lock, lost and relock mode
   task w(input int n, input logic [2:0] e);
      repeat (n) @(posedge clk);
      #1 ck("lk", {5'h00, e}, {5'h00, lock_indication_status, phase_lost,
         relock_mode});
   endtask : w
   task summarize;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // Watchdog
   initial begin
      #200000;
      errors++;
      summarize;
   end
   // Tests
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd(4'h0, 8'ha2);
      w(0, 3'b000);
      w(12, 3'b100);
      wr(4'h0, 8'hff);
      rd(4'h0, 8'he7);
      rd(4'h7, 8'h00);
      $display("test regs done");
      @(posedge clk) coarse_loss <= 1'b1;
      w(2, 3'b011);
      ck("irq", 8'h00, {7'h00, irq});
      wr(4'h3, 8'h03);
      #1 ck("irq", 8'h01, {7'h00, irq});
      @(posedge clk) coarse_loss <= 1'b0;
      w(12, 3'b100);
      rd(4'h2, 8'h03);
      wr(4'h2, 8'h03);
      rd(4'h2, 8'h00);
      ck("irq", 8'h00, {7'h00, irq});
      $display("test coarse done");
      @(posedge clk) phase_valid <= 1'b1;
      for (int f = 0; f < 8; f++) begin
         wr(4'h0, 8'h80 | 8'(f));
         @(posedge clk) phase_err_mag <= 16'((f + 1) * 1024);
         w(3, 3'b100);
         @(posedge clk) phase_err_mag <= 16'((f + 1) * 1024 + 1);
         w(2, 3'b011);
         @(posedge clk) phase_err_mag <= 16'h0000;
         w(12, 3'b100);
      end
      wr(4'h0, 8'h02);
      @(posedge clk) phase_err_mag <= 16'hffff;
      w(4, 3'b100);
      $display("test window done");
      wr(4'h0, 8'h40);
      @(posedge clk) ref_active <= 1'b0;
      w(5, 3'b011);
      @(posedge clk) ref_active <= 1'b1;
      w(12, 3'b100);
      wr(4'h0, 8'h00);
      @(posedge clk) ref_active <= 1'b0;
      w(6, 3'b100);
      $display("test inactivity done");
      summarize;
   end
endmodule : phase_loss_detector_test
